// ---- bench/fsp_ctrl_model.sv ----
`timescale 1ns/1ps
module fsp_ctrl_model #(
  parameter int NCH = 4
) (
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  input  wire logic           go_i,
  input  wire logic           rude_i,
  input  wire logic           cause_gone_i,
  input  wire logic [NCH-1:0] tele_in_i,
  input  wire logic           passive_i,
  output logic                reint_req_o,
  output logic                estop_o
);
  // Rude mode asks even with a fault left
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      reint_req_o <= 1'b0;
    else
      reint_req_o <= go_i && (cause_gone_i || rude_i);
  end
  assign estop_o = !passive_i && (|tele_in_i);
endmodule // fsp_ctrl_model

// ---- bench/fsp_passivation_properties.sv ----
`timescale 1ns/1ps
module fsp_passivation_properties #(
  parameter int NCH = 4
) (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               ce_i,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic [7:0]         wb_adr_i,
  input wire logic               wb_ack_o,
  input wire logic [NCH-1:0]     safe_in_i,
  input wire logic [NCH-1:0]     short_i,
  input wire logic [NCH-1:0]     discr_i,
  input wire logic               config_err_i,
  input wire logic               comm_err_i,
  input wire logic               sensor_err_i,
  input wire logic               addr_err_i,
  input wire logic               serious_err_i,
  input wire logic               version_err_i,
  input wire logic               reint_req_i,
  input wire logic [NCH-1:0]     tele_in_o,
  input wire logic               passive_o,
  input wire logic               link_up_o,
  input wire logic               safety_word_a_valid_o,
  input wire fsp_pkg::fsp_safety_word_a_t safety_word_a_o
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic flt;
  logic ctrl_wr;
  assign flt = (|short_i) || (|discr_i) || config_err_i || comm_err_i || sensor_err_i
             || addr_err_i || serious_err_i || version_err_i;
  assign ctrl_wr = wb_cyc_i && wb_stb_i && wb_we_i && (wb_adr_i == fsp_pkg::ADDR_CTRL);
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");
  property p_fault;
    ce_i && !passive_o && flt |=> passive_o;
  endproperty
  a_fault: assert property (p_fault) else $error("fault did not passivate");
  property p_zero;
    passive_o |-> tele_in_o == '0;
  endproperty
  a_zero: assert property (p_zero) else $error("passive inputs not zero");
  property p_boot;
    $fell(rst_i) |-> passive_o && link_up_o;
  endproperty
  a_boot: assert property (p_boot) else $error("not passive after reset");
  property p_latch;
    passive_o && ce_i && !reint_req_i && !ctrl_wr |=> passive_o;
  endproperty
  a_latch: assert property (p_latch) else $error("passive left without request");
  property p_refuse;
    passive_o && flt |=> passive_o;
  endproperty
  a_refuse: assert property (p_refuse) else $error("left passive with fault");
  property p_live;
    !passive_o && $past(!passive_o) && $past(ce_i) |-> tele_in_o == $past(safe_in_i);
  endproperty
  a_live: assert property (p_live) else $error("live value not delivered");
  property p_serious;
    ce_i && serious_err_i |=> passive_o && !link_up_o;
  endproperty
  a_serious: assert property (p_serious) else $error("serious error not handled");
  property p_no_safety_word_a;
    ce_i && (serious_err_i || !link_up_o) |=> !safety_word_a_valid_o;
  endproperty
  a_no_safety_word_a: assert property (p_no_safety_word_a) else $error("serious code was sent");
  property p_comm_safety_word_a;
    ce_i && $rose(comm_err_i) && !(|short_i) && !(|discr_i) && !config_err_i
      && !serious_err_i && link_up_o
      |=> safety_word_a_valid_o && safety_word_a_o == {fsp_pkg::CHAN_MODULE, fsp_pkg::SAFETY_WORD_A_COMM};
  endproperty
  a_comm_safety_word_a: assert property (p_comm_safety_word_a) else $error("comm safety_word_a wrong");
  property p_short_safety_word_a;
    ce_i && $rose(short_i[0]) && !serious_err_i && link_up_o
      |=> safety_word_a_valid_o && safety_word_a_o == {8'h00, fsp_pkg::SAFETY_WORD_A_SHORT};
  endproperty
  a_short_safety_word_a: assert property (p_short_safety_word_a) else $error("short safety_word_a wrong");
  c_ack: cover property (wb_ack_o);
  c_pass: cover property ($rose(passive_o));
  c_reint: cover property ($fell(passive_o));
  c_dead: cover property ($fell(link_up_o));
endmodule // fsp_passivation_properties

bind fsp_passivation fsp_passivation_properties #(.NCH(NCH)) u_chk (
  .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o, .safe_in_i,
  .short_i, .discr_i, .config_err_i, .comm_err_i, .sensor_err_i, .addr_err_i,
  .serious_err_i, .version_err_i, .reint_req_i, .tele_in_o, .passive_o, .link_up_o,
  .safety_word_a_valid_o, .safety_word_a_o
);

// ---- bench/fsp_passivation_tb_top.sv ----
`timescale 1ns/1ps
module fsp_passivation_tb_top;
  localparam int NCH = 4;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               ce_i = 1'b1;
  logic               wb_cyc_i = 1'b0;
  logic               wb_stb_i = 1'b0;
  logic               wb_we_i = 1'b0;
  logic [3:0]         wb_sel_i = 4'hF;
  logic [7:0]         wb_adr_i = 8'h00;
  logic [31:0]        wb_dat_i = 32'h00000000;
  logic [31:0]        wb_dat_o;
  logic               wb_ack_o;
  logic [NCH-1:0]     safe_in_i = 4'hA;
  logic [7:0]         flt = 8'h00;
  logic [1:0]         ch = 2'd0;
  logic               go = 1'b0;
  logic               rude = 1'b0;
  logic               estop;
  logic [NCH-1:0]     short_i, discr_i, tele_in_o;
  logic               config_err_i, comm_err_i, sensor_err_i, addr_err_i;
  logic               serious_err_i, version_err_i, reint_req_i;
  logic               passive_o, link_up_o, safety_word_a_valid_o, irq_o;
  fsp_pkg::fsp_safety_word_a_t safety_word_a_o;
  logic [7:0]         code [8] = '{fsp_pkg::SAFETY_WORD_A_SHORT, fsp_pkg::SAFETY_WORD_A_DISCR,
    fsp_pkg::SAFETY_WORD_A_CONFIG, fsp_pkg::SAFETY_WORD_A_COMM, fsp_pkg::SAFETY_WORD_A_SENSOR, fsp_pkg::SAFETY_WORD_A_ADDR,
    fsp_pkg::SAFETY_WORD_A_SERIOUS, fsp_pkg::SAFETY_WORD_A_VERSION};
  int                 n_fail = 0;
  int                 samples_checked = 0;
  int                 n_safety_word_a = 0;
  int                 m;
  logic [15:0]        exp_d;
  assign short_i = flt[0] ? (4'h1 << ch) : 4'h0;
  assign discr_i = flt[1] ? (4'h1 << ch) : 4'h0;
  assign {version_err_i, serious_err_i, addr_err_i, sensor_err_i} = flt[7:4];
  assign {comm_err_i, config_err_i} = flt[3:2];
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (safety_word_a_valid_o === 1'b1) n_safety_word_a++;
  fsp_passivation #(.NCH(NCH)) DUT (
    .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i, .wb_adr_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .safe_in_i, .short_i, .discr_i, .config_err_i,
    .comm_err_i, .sensor_err_i, .addr_err_i, .serious_err_i, .version_err_i,
    .reint_req_i, .tele_in_o, .passive_o, .link_up_o, .safety_word_a_valid_o, .safety_word_a_o,
    .irq_o
  );
  fsp_ctrl_model #(.NCH(NCH)) u_ctl (
    .clk_i, .rst_i, .go_i(go), .rude_i(rude), .cause_gone_i(flt == 8'h00),
    .tele_in_i(tele_in_o), .passive_i(passive_o), .reint_req_o(reint_req_i), .estop_o(estop)
  );
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic nap(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      n_fail++;
      conclude();
    end
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h00000000, q);
    check(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic reint(input logic r);
    @(posedge clk_i);
    {go, rude} <= {1'b1, r};
    @(posedge clk_i);
    go <= 1'b0;
    nap(3);
  endtask
  task automatic set_f(input logic [7:0] f, input logic [1:0] c);
    @(posedge clk_i);
    {flt, ch} <= {f, c};
  endtask
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial
  begin
    nap(2);
    rst_i <= 1'b0;
    check({link_up_o, passive_o, tele_in_o}, 6'h30);
    rd(fsp_pkg::ADDR_STATUS, 32'h00000003);
    rd(fsp_pkg::ADDR_WDT, 32'h00000064);
    rd(fsp_pkg::ADDR_WDT_MIN, 32'h0000000A);
    rd(fsp_pkg::ADDR_IRQ_MASK, 32'h00000000);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h00000000);
    reint(1'b0);
    rd(fsp_pkg::ADDR_STATUS, 32'h00000002);
    check({estop, tele_in_o}, {1'b1, safe_in_i});
    wr(fsp_pkg::ADDR_IRQ_MASK, 32'h00000001);
    for (int k = 0; k < 8; k++)
    begin
      if (k != 6)
      begin
        set_f(8'h01 << k, (k == 1) ? 2'd2 : 2'd0);
        nap(3);
        check({irq_o, passive_o, tele_in_o}, 6'h30);
        exp_d = {(k < 2) ? {6'h00, ch} : fsp_pkg::CHAN_MODULE, code[k]};
        rd(fsp_pkg::ADDR_SAFETY_WORD_A, {16'h0000, exp_d});
        check(safety_word_a_o, exp_d);
        reint(1'b1);
        check(passive_o, 1'b1);
        set_f(8'h00, 2'd0);
        reint(1'b0);
        check({passive_o, tele_in_o}, {1'b0, safe_in_i});
        wr(fsp_pkg::ADDR_IRQ_STAT, 32'h00000007);
        nap(1);
        check(irq_o, 1'b0);
      end
    end
    wr(fsp_pkg::ADDR_WDT, 32'h00000005);
    nap(2);
    rd(fsp_pkg::ADDR_SAFETY_WORD_A, {16'h0000, fsp_pkg::CHAN_MODULE, fsp_pkg::SAFETY_WORD_A_CONFIG});
    check(passive_o, 1'b1);
    wr(fsp_pkg::ADDR_WDT, 32'h00000064);
    wr(fsp_pkg::ADDR_CTRL, 32'h00000003);
    nap(2);
    check(passive_o, 1'b0);
    ce_i <= 1'b0;
    set_f(8'h08, 2'd0);
    nap(3);
    check({passive_o, tele_in_o}, {1'b0, safe_in_i});
    ce_i <= 1'b1;
    nap(2);
    check(passive_o, 1'b1);
    set_f(8'h00, 2'd0);
    reint(1'b0);
    check(passive_o, 1'b0);
    m = n_safety_word_a;
    set_f(8'h40, 2'd0);
    reint(1'b1);
    check({passive_o, link_up_o}, 2'b10);
    check(n_safety_word_a, m);
    @(posedge clk_i);
    {rst_i, flt} <= {1'b1, 8'h28};
    nap(2);
    m = n_safety_word_a;
    rst_i <= 1'b0;
    nap(4);
    check(n_safety_word_a, m + 1);
    rd(fsp_pkg::ADDR_SAFETY_WORD_A, {16'h0000, fsp_pkg::CHAN_MODULE, fsp_pkg::SAFETY_WORD_A_COMM});
    check({passive_o, link_up_o}, 2'b11);
    conclude();
  end
  initial
  begin
    nap(20000);
    n_fail++;
    conclude();
  end
endmodule // fsp_passivation_tb_top

// ---- include/fsp_pkg.sv ----
package fsp_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_FAULT    = 8'h08;
  localparam logic [7:0] ADDR_LIVE     = 8'h0C;
  localparam logic [7:0] ADDR_SAFE_IN  = 8'h10;
  localparam logic [7:0] ADDR_SAFETY_WORD_A     = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
  localparam logic [7:0] ADDR_WDT      = 8'h20;
  localparam logic [7:0] ADDR_WDT_MIN  = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_REINT_BIT   = 0;
  localparam int CTRL_FSMODE_BIT  = 1;
  localparam int STAT_PASS_BIT    = 0;
  localparam int STAT_LINK_BIT    = 1;
  localparam int STAT_DVALID_BIT  = 2;

  // Fault flags in the fault word
  localparam int FLT_SHORT   = 0;
  localparam int FLT_DISCR   = 1;
  localparam int FLT_CONFIG  = 2;
  localparam int FLT_COMM    = 3;
  localparam int FLT_SENSOR  = 4;
  localparam int FLT_ADDR    = 5;
  localparam int FLT_SERIOUS = 6;
  localparam int FLT_VERSION = 7;
  localparam int FLT_WIDTH   = 8;

  // Interrupt status bits
  localparam int IRQ_PASS  = 0;
  localparam int IRQ_SAFETY_WORD_A  = 1;
  localparam int IRQ_INPUT = 2;
  localparam int IRQ_W     = 3;

  // ----------------------------------------------------------------
  // Diagnostic codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SAFETY_WORD_A_SHORT   = 8'h01;
  localparam logic [7:0] SAFETY_WORD_A_CONFIG  = 8'h10;
  localparam logic [7:0] SAFETY_WORD_A_COMM    = 8'h13;
  localparam logic [7:0] SAFETY_WORD_A_DISCR   = 8'h19;
  localparam logic [7:0] SAFETY_WORD_A_SENSOR  = 8'h1C;
  localparam logic [7:0] SAFETY_WORD_A_ADDR    = 8'h1D;
  localparam logic [7:0] SAFETY_WORD_A_SERIOUS = 8'h1E;
  localparam logic [7:0] SAFETY_WORD_A_VERSION = 8'h1F;

  localparam logic [7:0] CHAN_MODULE  = 8'hFF;
  localparam logic [15:0] WDT_RESET   = 16'h0064;
  localparam logic [15:0] WDT_MIN_RST = 16'h000A;
  localparam logic [31:0] WB_ZERO     = 32'h00000000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] chan;
    logic [7:0] code;
  } fsp_safety_word_a_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } fsp_wb_req_t;

  typedef enum logic [1:0] {
    ST_PASSIVE,
    ST_ACTIVE,
    ST_DEAD
  } fsp_state_t;

endpackage

// ---- verilog/fsp_passivation.sv ----
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ps

// What this block does
// - Any detected fault in fail-safe mode passivates all safety channels together.
// - Passivated channels report fixed zero instead of live values; not configurable.
// - Device is passive right after power-up, before any reintegration.
// - Safety parameter error, such as watchdog time too short, passivates.
// - Safety protocol communication error with the controller passivates.
// - Short, discrepancy or internal fault passivates.
// - Passivation status bit: 0 not passive, 1 passive.
// - No fault memory across restarts; report one present fault after startup.
// - After reintegration live safety input values are delivered again.
// - Diagnostics active until the link drops; sent automatically on each new fault except a serious one.
// - Channel codes: 0x01 short circuit, 0x19 discrepancy.
// - Module codes: 0x10 configuration, 0x13 communication, 0x1C sensor setting.
// - Module codes: 0x1D address mismatch, 0x1E serious, 0x1F version conflict.
// - Serious failure drops link, passivates, sends no diagnostic.
// - Emergency stop or sensor actuation bit sent in safety telegram.
module fsp_passivation #(
  parameter int NCH = 4
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Live inputs and fault sources
  input  wire logic [NCH-1:0]    safe_in_i,
  input  wire logic [NCH-1:0]    short_i,
  input  wire logic [NCH-1:0]    discr_i,
  input  wire logic              config_err_i,
  input  wire logic              comm_err_i,
  input  wire logic              sensor_err_i,
  input  wire logic              addr_err_i,
  input  wire logic              serious_err_i,
  input  wire logic              version_err_i,
  input  wire logic              reint_req_i,
  // Telegram side
  output logic      [NCH-1:0]    tele_in_o,
  output logic                   passive_o,
  output logic                   link_up_o,
  output logic                   safety_word_a_valid_o,
  output fsp_pkg::fsp_safety_word_a_t     safety_word_a_o,
  output logic                   irq_o
);

  // Elaboration check: fault word and read lanes serve at most 8 channels
  if (NCH < 1 || NCH > 8)
  begin : g_nch_check
    $error("fsp_passivation: NCH must be 1..8");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fsp_pkg::fsp_state_t        state_reg;
  logic                       fsmode_reg;
  logic [15:0]                wdt_reg;
  logic [15:0]                wdt_min_reg;
  logic [NCH-1:0]             tele_reg;
  fsp_pkg::fsp_safety_word_a_t         safety_word_a_reg;
  fsp_pkg::fsp_safety_word_a_t         safety_word_a_next;
  logic                       safety_word_a_valid_reg;
  logic [fsp_pkg::FLT_WIDTH-1:0] fault_now;
  logic [fsp_pkg::FLT_WIDTH-1:0] fault_prev_reg;
  logic [fsp_pkg::IRQ_W-1:0]  irq_stat_reg;
  logic [fsp_pkg::IRQ_W-1:0]  irq_mask_reg;
  logic [fsp_pkg::IRQ_W-1:0]  irq_set;
  logic [NCH-1:0]             in_prev_reg;
  logic                       any_fault;
  logic                       new_fault;
  logic                       wdt_err;
  logic                       bus_req;
  logic                       bus_wr;
  logic                       reint_sw;
  logic                       pass_prev_reg;
  logic                       stay_active;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land on the edge where the master sees ack high
  assign bus_wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign reint_sw = bus_wr && wb_sel_i[0] && (wb_adr_i == fsp_pkg::ADDR_CTRL)
                    && wb_dat_i[fsp_pkg::CTRL_REINT_BIT];

  // ----------------------------------------------------------------
  // Fault collection
  // ----------------------------------------------------------------
  assign wdt_err = wdt_reg < wdt_min_reg;

  always_comb
  begin
    fault_now                       = '0;
    fault_now[fsp_pkg::FLT_SHORT]   = |short_i;
    fault_now[fsp_pkg::FLT_DISCR]   = |discr_i;
    fault_now[fsp_pkg::FLT_CONFIG]  = config_err_i || wdt_err;
    fault_now[fsp_pkg::FLT_COMM]    = comm_err_i;
    fault_now[fsp_pkg::FLT_SENSOR]  = sensor_err_i;
    fault_now[fsp_pkg::FLT_ADDR]    = addr_err_i;
    fault_now[fsp_pkg::FLT_SERIOUS] = serious_err_i;
    fault_now[fsp_pkg::FLT_VERSION] = version_err_i;
  end

  assign any_fault = |fault_now;
  assign new_fault = |(fault_now & ~fault_prev_reg);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fault_prev_reg <= '0;
    else if (ce_i)
      fault_prev_reg <= fault_now;
  end

  // ----------------------------------------------------------------
  // Passivation state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_reg <= fsp_pkg::ST_PASSIVE;
    else if (ce_i)
    begin
      case (state_reg)
        fsp_pkg::ST_PASSIVE:
          if (serious_err_i)
            state_reg <= fsp_pkg::ST_DEAD;
          else if ((reint_req_i || reint_sw) && !any_fault)
            state_reg <= fsp_pkg::ST_ACTIVE;
        fsp_pkg::ST_ACTIVE:
          if (serious_err_i)
            state_reg <= fsp_pkg::ST_DEAD;
          else if (any_fault && fsmode_reg)
            state_reg <= fsp_pkg::ST_PASSIVE;
        fsp_pkg::ST_DEAD:
          state_reg <= fsp_pkg::ST_DEAD;
        default:
          state_reg <= fsp_pkg::ST_PASSIVE;
      endcase
    end
  end

  assign passive_o = (state_reg != fsp_pkg::ST_ACTIVE);
  assign link_up_o = (state_reg != fsp_pkg::ST_DEAD);

  // Live values only while no passivating cause is seen this cycle
  assign stay_active = (state_reg == fsp_pkg::ST_ACTIVE) && !serious_err_i
                       && !(any_fault && fsmode_reg);

  // ----------------------------------------------------------------
  // Telegram values
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tele_reg <= '0;
    else if (ce_i)
    begin
      if (stay_active)
        tele_reg <= safe_in_i;
      else
        tele_reg <= '0;
    end
  end

  assign tele_in_o = tele_reg;

  // ----------------------------------------------------------------
  // Diagnostics: lowest-numbered present fault wins
  // ----------------------------------------------------------------
  always_comb
  begin
    safety_word_a_next = '{chan: fsp_pkg::CHAN_MODULE, code: 8'h00};
    if (fault_now[fsp_pkg::FLT_VERSION])
      safety_word_a_next.code = fsp_pkg::SAFETY_WORD_A_VERSION;
    if (fault_now[fsp_pkg::FLT_ADDR])
      safety_word_a_next.code = fsp_pkg::SAFETY_WORD_A_ADDR;
    if (fault_now[fsp_pkg::FLT_SENSOR])
      safety_word_a_next.code = fsp_pkg::SAFETY_WORD_A_SENSOR;
    if (fault_now[fsp_pkg::FLT_COMM])
      safety_word_a_next.code = fsp_pkg::SAFETY_WORD_A_COMM;
    if (fault_now[fsp_pkg::FLT_CONFIG])
      safety_word_a_next.code = fsp_pkg::SAFETY_WORD_A_CONFIG;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (discr_i[i])
        safety_word_a_next = '{chan: 8'(i), code: fsp_pkg::SAFETY_WORD_A_DISCR};
    end
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (short_i[i])
        safety_word_a_next = '{chan: 8'(i), code: fsp_pkg::SAFETY_WORD_A_SHORT};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      safety_word_a_reg       <= '0;
      safety_word_a_valid_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      safety_word_a_valid_reg <= 1'b0;
      if (serious_err_i || state_reg == fsp_pkg::ST_DEAD)
        safety_word_a_valid_reg <= 1'b0;
      else if (new_fault)
      begin
        safety_word_a_reg       <= safety_word_a_next;
        safety_word_a_valid_reg <= 1'b1;
      end
    end
  end

  assign safety_word_a_valid_o    = safety_word_a_valid_reg;
  assign safety_word_a_o = safety_word_a_reg;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Starts high so reset does not look like a fresh passivation
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pass_prev_reg <= 1'b1;
    else if (ce_i)
      pass_prev_reg <= passive_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      in_prev_reg <= '0;
    else if (ce_i)
      in_prev_reg <= tele_in_o;
  end

  always_comb
  begin
    irq_set                   = '0;
    irq_set[fsp_pkg::IRQ_PASS]  = passive_o && !pass_prev_reg;
    irq_set[fsp_pkg::IRQ_SAFETY_WORD_A]  = safety_word_a_valid_reg;
    irq_set[fsp_pkg::IRQ_INPUT] = |(tele_in_o & ~in_prev_reg);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_stat_reg <= '0;
    else if (ce_i)
    begin
      if (bus_wr && wb_sel_i[0] && wb_adr_i == fsp_pkg::ADDR_IRQ_STAT)
        irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[fsp_pkg::IRQ_W-1:0]) | irq_set;
      else
        irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fsmode_reg <= 1'b1;
    else if (ce_i && bus_wr && wb_sel_i[0])
    begin
      if (wb_adr_i == fsp_pkg::ADDR_CTRL)
        fsmode_reg <= wb_dat_i[fsp_pkg::CTRL_FSMODE_BIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_mask_reg <= '0;
    else if (ce_i && bus_wr && wb_sel_i[0])
    begin
      if (wb_adr_i == fsp_pkg::ADDR_IRQ_MASK)
        irq_mask_reg <= wb_dat_i[fsp_pkg::IRQ_W-1:0];
    end
  end

  // Watchdog time and its minimum, written per byte lane
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wdt_reg <= fsp_pkg::WDT_RESET;
    else if (ce_i && bus_wr)
    begin
      if (wb_adr_i == fsp_pkg::ADDR_WDT)
      begin
        if (wb_sel_i[0])
          wdt_reg[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          wdt_reg[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wdt_min_reg <= fsp_pkg::WDT_MIN_RST;
    else if (ce_i && bus_wr)
    begin
      if (wb_adr_i == fsp_pkg::ADDR_WDT_MIN)
      begin
        if (wb_sel_i[0])
          wdt_min_reg[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          wdt_min_reg[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path and acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= fsp_pkg::WB_ZERO;
    end
    else if (ce_i)
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= fsp_pkg::WB_ZERO;
      if (bus_req && !wb_we_i)
      begin
        if (wb_adr_i == fsp_pkg::ADDR_CTRL)
          wb_dat_o[fsp_pkg::CTRL_FSMODE_BIT] <= fsmode_reg;
        else if (wb_adr_i == fsp_pkg::ADDR_STATUS)
        begin
          wb_dat_o[fsp_pkg::STAT_PASS_BIT]   <= passive_o;
          wb_dat_o[fsp_pkg::STAT_LINK_BIT]   <= link_up_o;
          wb_dat_o[fsp_pkg::STAT_DVALID_BIT] <= safety_word_a_valid_reg;
        end
        else if (wb_adr_i == fsp_pkg::ADDR_FAULT)
          wb_dat_o[fsp_pkg::FLT_WIDTH-1:0] <= fault_now;
        else if (wb_adr_i == fsp_pkg::ADDR_LIVE)
          wb_dat_o[NCH-1:0] <= safe_in_i;
        else if (wb_adr_i == fsp_pkg::ADDR_SAFE_IN)
          wb_dat_o[NCH-1:0] <= tele_in_o;
        else if (wb_adr_i == fsp_pkg::ADDR_SAFETY_WORD_A)
          wb_dat_o[15:0] <= safety_word_a_reg;
        else if (wb_adr_i == fsp_pkg::ADDR_IRQ_STAT)
          wb_dat_o[fsp_pkg::IRQ_W-1:0] <= irq_stat_reg;
        else if (wb_adr_i == fsp_pkg::ADDR_IRQ_MASK)
          wb_dat_o[fsp_pkg::IRQ_W-1:0] <= irq_mask_reg;
        else if (wb_adr_i == fsp_pkg::ADDR_WDT)
          wb_dat_o[15:0] <= wdt_reg;
        else if (wb_adr_i == fsp_pkg::ADDR_WDT_MIN)
          wb_dat_o[15:0] <= wdt_min_reg;
      end
    end
  end

endmodule // fsp_passivation
